// file: rtl/adcs_top.sv
/*
 * Control and status sequencer of an eight-channel 10-bit converter:
 * control/status and trigger registers, result registers, single and scan
 * sequencing, trigger start, completion flag and interrupt request.
 * Assumes a classic Wishbone master on the same clock, an analog core that
 * samples on CONV_SAMPLE_O and holds its result on CONV_RESULT_I by the end
 * of the conversion time, and standby and DMA strobes from the same clock.
 */
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

`include "adcs_cfg.svh"

// Contract
// - Eight-bit read/write control/status register.
// - Reset and standby clear it to zero.
// - End flag takes only written zero.
// - Flag clears only after read-one-then-write-zero.
// - DMA result access after completion clears flag; here only while interrupt enable is set.
// - Single mode sets flag at conversion end.
// - Scan sets flag after whole group pass.
// - Interrupt enable gates the completion request.
// - Start bit shows busy; trigger sets it.
// - Start bit zero keeps conversion halted.
// - Single mode converts once, clears start.
// - Scan repeats until start bit cleared.
// - Mode bit: zero single, one scan.
// - Time bit selects 266 or 134 states.
// - Group bit plus index select channels.
// - Channel k and k+4 share result register.
// - Result high eight bits, low two on top.
// - Enabled trigger starts on falling pin edge.
// - Each scan starts at group's first channel.
module adcs_top (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        TRIG_N_I,
    input  wire logic        STANDBY_I,
    input  wire logic        DMA_RESULT_ACCESS_I,
    input  wire logic [9:0]  CONV_RESULT_I,
    output logic      [2:0]  CONV_CH_O,
    output logic             CONV_SAMPLE_O,
    output logic             CONV_BUSY_O,
    output logic             COMPLETION_IRQ_O
);

    // =================================================================
    // State
    // =================================================================
    typedef struct packed {
        adcs_pkg::adcs_csr_s  csr;
        logic                 trg_en;
        logic                 armed;
        adcs_pkg::adcs_fsm_e  fsm;
        logic [1:0]           cur;
        logic [3:0][9:0]      res;
        logic                 ack;
        logic [31:0]          dat;
        logic [2:0]           ch;
        logic                 sample;
        logic                 busy;
        logic                 irq;
    } adcs_top_s;

    adcs_top_s            r;
    adcs_top_s            n;
    adcs_pkg::adcs_tcmd_s tcmd;
    logic                 trig_fall;
    logic                 conv_done;
    logic                 acc;
    logic                 rd_req;
    logic                 wr_take;
    logic [7:0]           adr;
    logic [7:0]           res_ofs;
    logic                 res_hit;
    logic                 set_end;
    logic                 clr_end;
    logic                 hw_stop;

    // =================================================================
    // Helpers
    // =================================================================
    adcs_trig_sync u_trig (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .pin_i  (TRIG_N_I),
        .fall_o (trig_fall)
    );

    adcs_conv_timer #(
        .CW (9)
    ) u_timer (
        .clk_i  (CLK_SYS_I),
        .rst_i  (RST_I),
        .cmd_i  (tcmd),
        .done_o (conv_done)
    );

    // =================================================================
    // Address decode
    // =================================================================
    assign adr     = {WB_ADR_I[7:2], 2'b00};
    assign res_ofs = adr - `ADCS_OFS_RES_BASE;
    assign res_hit = (adr >= `ADCS_OFS_RES_BASE) && (adr <= `ADCS_OFS_RES_LAST);

    // =================================================================
    // Read data mux
    // =================================================================
    function automatic logic [31:0] read_word(input adcs_top_s s,
                                              input logic [7:0] a,
                                              input logic hit,
                                              input logic [1:0] ri);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == `ADCS_OFS_CSR) begin
            w[7:0] = s.csr;
        end else if (a == `ADCS_OFS_TRG) begin
            w[7:0] = {s.trg_en, `ADCS_TRG_RESERVED};
        end else if (hit) begin
            w[15:0] = {s.res[ri][9:2], s.res[ri][1:0], 6'h00};
        end
        return w;
    endfunction

    // =================================================================
    // Next state
    // =================================================================
    always_comb begin
        n        = r;
        tcmd     = '0;
        n.ack    = 1'b0;
        n.sample = 1'b0;
        set_end  = 1'b0;
        clr_end  = 1'b0;
        hw_stop  = 1'b0;
        acc      = WB_CYC_I & WB_STB_I;
        rd_req   = acc & ~WB_WE_I & ~r.ack;
        wr_take  = acc & WB_WE_I & r.ack & WB_SEL_I[0];

        // Bus answer one cycle after the request; data held with ack.
        if (acc && !r.ack) begin
            n.ack = 1'b1;
            n.dat = WB_WE_I ? 32'h0000_0000 : read_word(r, adr, res_hit, res_ofs[3:2]);
        end

        // A read that returns the flag set arms the clearing write.
        if (rd_req && adr == `ADCS_OFS_CSR && r.csr.end_flag) begin
            n.armed = 1'b1;
        end

        // Conversion sequencer.
        case (r.fsm)
            adcs_pkg::ADCS_IDLE: begin
                if (r.csr.start) begin
                    tcmd.load  = 1'b1;
                    tcmd.first = 1'b1;
                    tcmd.fast  = r.csr.tsel;
                    n.cur      = r.csr.scan ? 2'h0 : r.csr.idx;
                    n.fsm      = adcs_pkg::ADCS_CONV;
                    n.sample   = 1'b1;
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (!r.csr.start) begin
                    tcmd.abort = 1'b1;
                    n.fsm      = adcs_pkg::ADCS_IDLE;
                end else if (conv_done) begin
                    n.res[r.cur] = CONV_RESULT_I;
                    if (!r.csr.scan) begin
                        set_end = 1'b1;
                        hw_stop = 1'b1;
                        n.fsm   = adcs_pkg::ADCS_IDLE;
                    end else begin
                        if (r.cur == r.csr.idx) begin
                            set_end = 1'b1;
                            n.cur   = 2'h0;
                        end else begin
                            n.cur = r.cur + 2'h1;
                        end
                        tcmd.load = 1'b1;
                        tcmd.fast = r.csr.tsel;
                        n.sample  = 1'b1;
                    end
                end
            end
            default: begin
                tcmd.abort = 1'b1;
                n.fsm      = adcs_pkg::ADCS_IDLE;
            end
        endcase

        if (hw_stop) begin
            n.csr.start = 1'b0;
        end
        if (trig_fall && r.trg_en) begin
            n.csr.start = 1'b1;
        end

        // Register writes take effect at the edge that sees ack high.
        if (wr_take) begin
            if (adr == `ADCS_OFS_CSR) begin
                n.csr.irq_en = WB_DAT_I[`ADCS_BIT_IRQE];
                n.csr.start  = WB_DAT_I[`ADCS_BIT_START];
                n.csr.scan   = WB_DAT_I[`ADCS_BIT_SCAN];
                n.csr.tsel   = WB_DAT_I[`ADCS_BIT_TSEL];
                n.csr.grp    = WB_DAT_I[`ADCS_BIT_GRP];
                n.csr.idx    = WB_DAT_I[1:0];
                if (!WB_DAT_I[`ADCS_BIT_END] && r.armed) begin
                    clr_end = 1'b1;
                    n.armed = 1'b0;
                end
            end else if (adr == `ADCS_OFS_TRG) begin
                n.trg_en = WB_DAT_I[`ADCS_BIT_TRG_EN];
            end
        end

        if (DMA_RESULT_ACCESS_I && r.irq) begin
            clr_end = 1'b1;
        end

        // A completion in the clearing cycle keeps the flag set.
        if (set_end) begin
            n.csr.end_flag = 1'b1;
        end else if (clr_end) begin
            n.csr.end_flag = 1'b0;
        end
        if (!n.csr.end_flag) begin
            n.armed = 1'b0;
        end

        // Standby clears everything but the bus answer.
        if (STANDBY_I) begin
            n.csr      = `ADCS_CSR_RST;
            n.trg_en   = 1'b0;
            n.armed    = 1'b0;
            n.res      = '0;
            n.cur      = 2'h0;
            n.fsm      = adcs_pkg::ADCS_IDLE;
            n.sample   = 1'b0;
            tcmd       = '0;
            tcmd.abort = 1'b1;
        end

        n.ch   = {n.csr.grp, n.cur};
        n.busy = (n.fsm == adcs_pkg::ADCS_CONV);
        n.irq  = n.csr.end_flag & n.csr.irq_en;
    end

    // =================================================================
    // Registers
    // =================================================================
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            r     <= '0;
            r.csr <= `ADCS_CSR_RST;
            r.fsm <= adcs_pkg::ADCS_IDLE;
        end else begin
            r <= n;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    assign WB_DAT_O         = r.dat;
    assign WB_ACK_O         = r.ack;
    assign CONV_CH_O        = r.ch;
    assign CONV_SAMPLE_O    = r.sample;
    assign CONV_BUSY_O      = r.busy;
    assign COMPLETION_IRQ_O = r.irq;

endmodule

`default_nettype wire

// file: rtl/adcs_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the converter
 * control block. Assumes a 50 MHz system clock where one converter state is
 * one clock period, and a 32-bit classic Wishbone register bus.
 */
`ifndef ADCS_CFG_SVH
`define ADCS_CFG_SVH

// =====================================================================
// Register offsets (byte addresses, one aligned word each)
// =====================================================================
`define ADCS_OFS_CSR        8'h00
`define ADCS_OFS_TRG        8'h04
`define ADCS_OFS_RES_BASE   8'h08
`define ADCS_OFS_RES_LAST   8'h14

// =====================================================================
// Reset values and fields
// =====================================================================
`define ADCS_CSR_RST        8'h00
`define ADCS_TRG_RESERVED   7'h7f
`define ADCS_BIT_END        7
`define ADCS_BIT_IRQE       6
`define ADCS_BIT_START      5
`define ADCS_BIT_SCAN       4
`define ADCS_BIT_TSEL       3
`define ADCS_BIT_GRP        2
`define ADCS_BIT_TRG_EN     7

// =====================================================================
// Timing: times in converter states, counts in clock cycles
// =====================================================================
`define ADCS_CLK_NS         20
`define ADCS_STATE_NS       20
`define ADCS_FIRST_SLOW_ST  266
`define ADCS_FIRST_FAST_ST  134
`define ADCS_NEXT_SLOW_ST   256
`define ADCS_NEXT_FAST_ST   128
`define ADCS_CYC(st)        (((st) * `ADCS_STATE_NS) / `ADCS_CLK_NS)

`endif

// file: rtl/adcs_pkg.sv
/*
 * Types shared by the converter control block: sequencer states, the
 * control/status fields and the command sent to the conversion timer.
 * Assumes the constants of adcs_cfg.svh are included where numbers are used.
 */
package adcs_pkg;

    // =================================================================
    // Sequencer states
    // =================================================================
    typedef enum logic [1:0] {
        ADCS_IDLE = 2'b01,
        ADCS_CONV = 2'b10
    } adcs_fsm_e;

    // =================================================================
    // Control/status register fields, bit 7 down to bit 0
    // =================================================================
    typedef struct packed {
        logic       end_flag;
        logic       irq_en;
        logic       start;
        logic       scan;
        logic       tsel;
        logic       grp;
        logic [1:0] idx;
    } adcs_csr_s;

    // =================================================================
    // Command to the conversion timer
    // =================================================================
    typedef struct packed {
        logic load;
        logic first;
        logic fast;
        logic abort;
    } adcs_tcmd_s;

endpackage

// file: rtl/adcs_trig_sync.sv
/*
 * Synchroniser and falling-edge detector for the external trigger pin.
 * Assumes the pin is asynchronous to the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

module adcs_trig_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      fall_o
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
        logic fall;
    } adcs_sync_s;

    adcs_sync_s r;
    adcs_sync_s n;

    // =================================================================
    // Two flip-flops, then an edge detector on the second one
    // =================================================================
    always_comb begin
        n      = r;
        n.meta = pin_i;
        n.sync = r.meta;
        n.last = r.sync;
        n.fall = r.last & ~r.sync;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{meta: 1'b1, sync: 1'b1, last: 1'b1, fall: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign fall_o = r.fall;

endmodule

`default_nettype wire

// file: rtl/adcs_conv_timer.sv
/*
 * Conversion timer: counts one conversion, the first of a run long, the
 * following ones of a scan shorter, and pulses done at its end.
 * Assumes load and abort come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

`include "adcs_cfg.svh"

module adcs_conv_timer #(
    parameter int CW = 9
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire adcs_pkg::adcs_tcmd_s cmd_i,
    output logic                   done_o
);

    // A first run also spans the edge that registers the start bit, and every run ends one
    // edge after done, when the sequencer stores the result, so neither exceeds its state count.
    localparam logic [CW-1:0] LEN_FS = CW'(`ADCS_CYC(`ADCS_FIRST_SLOW_ST) - 3);
    localparam logic [CW-1:0] LEN_FF = CW'(`ADCS_CYC(`ADCS_FIRST_FAST_ST) - 3);
    localparam logic [CW-1:0] LEN_NS = CW'(`ADCS_CYC(`ADCS_NEXT_SLOW_ST) - 2);
    localparam logic [CW-1:0] LEN_NF = CW'(`ADCS_CYC(`ADCS_NEXT_FAST_ST) - 2);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
        logic          done;
    } adcs_tim_s;

    adcs_tim_s r;
    adcs_tim_s n;

    // =================================================================
    // Countdown
    // =================================================================
    always_comb begin
        n      = r;
        n.done = 1'b0;
        if (cmd_i.abort) begin
            n.busy = 1'b0;
        end else if (cmd_i.load) begin
            n.busy = 1'b1;
            if (cmd_i.first) begin
                n.cnt = cmd_i.fast ? LEN_FF : LEN_FS;
            end else begin
                n.cnt = cmd_i.fast ? LEN_NF : LEN_NS;
            end
        end else if (r.busy) begin
            if (r.cnt == '0) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign done_o = r.done;

endmodule

`default_nettype wire

// file: test/adcs_core_model.sv
/*
 * Model of the analog converter core behind the control block.
 * Assumes the sample strobe and channel come from adcs_top on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module adcs_core_model (
    input  wire logic       clk_i,
    input  wire logic       sample_i,
    input  wire logic [2:0] ch_i,
    output logic      [9:0] result_o
);
    // The result names its channel, so a store into the wrong register shows.
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            result_o <= {ch_i, 7'h35};
        end
    end
endmodule

`default_nettype wire

// file: test/adcs_top_chk.sv
/*
 * Port checker of the converter control block.
 * Assumes it is bound to adcs_top, with one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

module adcs_top_chk (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        STANDBY_I,
    input wire logic [2:0]  CONV_CH_O,
    input wire logic        CONV_SAMPLE_O,
    input wire logic        CONV_BUSY_O,
    input wire logic        COMPLETION_IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    ack_answer_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("request not acknowledged next cycle");
    ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without request");
    read_upper_zero_a: assert property ((WB_ACK_O && !WB_WE_I) |-> WB_DAT_O[31:16] == 16'h0)
        else $error("read data above bit 15 not zero");
    sample_busy_a: assert property (CONV_SAMPLE_O |-> CONV_BUSY_O)
        else $error("sample strobe while idle");
    busy_sample_a: assert property ($rose(CONV_BUSY_O) |-> CONV_SAMPLE_O)
        else $error("busy without sampling");
    ch_hold_a: assert property ((CONV_BUSY_O && $past(CONV_BUSY_O) && !CONV_SAMPLE_O) |-> $stable(CONV_CH_O))
        else $error("channel moved during conversion");
    sample_gap_a: assert property (CONV_SAMPLE_O |=> !CONV_SAMPLE_O [*8])
        else $error("conversions too close together");
    standby_stop_a: assert property (STANDBY_I |-> ##[1:3] (!CONV_BUSY_O && !COMPLETION_IRQ_O))
        else $error("standby did not stop the converter");
endmodule

bind adcs_top adcs_top_chk u_chk (
    .CLK_SYS_I        (CLK_SYS_I),
    .RST_I            (RST_I),
    .WB_CYC_I         (WB_CYC_I),
    .WB_STB_I         (WB_STB_I),
    .WB_WE_I          (WB_WE_I),
    .WB_ADR_I         (WB_ADR_I),
    .WB_DAT_O         (WB_DAT_O),
    .WB_ACK_O         (WB_ACK_O),
    .STANDBY_I        (STANDBY_I),
    .CONV_CH_O        (CONV_CH_O),
    .CONV_SAMPLE_O    (CONV_SAMPLE_O),
    .CONV_BUSY_O      (CONV_BUSY_O),
    .COMPLETION_IRQ_O (COMPLETION_IRQ_O)
);

`default_nettype wire

// file: test/tb_adcs_top.sv
/*
 * Self-checking bench of the converter control block.
 * Assumes the core model answers each sample and Wishbone acks next cycle.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_adcs_top;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        trig_n;
    logic        stby;
    logic        dma;
    logic [9:0]  res;
    logic [2:0]  ch;
    logic        smp;
    logic        busy;
    logic        irq;
    int          fails = 0;
    int          num_checks = 0;

    adcs_top DUT (.CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .TRIG_N_I(trig_n), .STANDBY_I(stby), .DMA_RESULT_ACCESS_I(dma), .CONV_RESULT_I(res),
        .CONV_CH_O(ch), .CONV_SAMPLE_O(smp), .CONV_BUSY_O(busy), .COMPLETION_IRQ_O(irq));
    adcs_core_model u_core (.clk_i(clk), .sample_i(smp), .ch_i(ch), .result_o(res));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    // Samples are seen at the edge, so the channel read there is the one sampled.
    task automatic wait_smp(output logic [2:0] c, output int t);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (smp !== 1'b1 && t < 400);
        c = ch;
    endtask

    task automatic wait_idle(output int t);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (busy !== 1'b0 && t < 400);
        check({31'h0, busy}, 32'h0);
        repeat (2) @(posedge clk);
    endtask

    function automatic logic [31:0] rexp(input logic [2:0] c);
        logic [9:0] r;
        r = {c, 7'h35};
        return {16'h0, r[9:2], r[1:0], 6'h0};
    endfunction

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset();
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h7f);
        for (int i = 0; i < 4; i++) begin
            rd(8'h08 + 8'(4 * i), 32'h0);
        end
        wr(8'h40, 32'hff);
        rd(8'h40, 32'h0);
        sel <= 4'he;
        wr(8'h00, 32'h40);
        sel <= 4'hf;
        rd(8'h00, 32'h0);
    endtask

    task automatic t_single();
        logic [2:0] c;
        int t;
        wr(8'h00, 32'h65);
        wait_smp(c, t);
        check({29'h0, c}, 32'h5);
        wait_idle(t);
        check(32'(t >= 259 && t <= 268), 32'h1);
        check({31'h0, irq}, 32'h1);
        wait_smp(c, t);
        check(32'(t >= 400), 32'h1);
        wr(8'h00, 32'h40);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(8'h00, 32'hc0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(8'h00, 32'hc0);
        wr(8'h00, 32'h40);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(8'h00, 32'h40);
        rd(8'h0c, rexp(3'h5));
    endtask

    task automatic t_scan();
        logic [2:0] c;
        int t;
        wr(8'h00, 32'h3a);
        for (int i = 0; i < 4; i++) begin
            wait_smp(c, t);
            check({29'h0, c}, 32'(i % 3));
            if (i == 1) begin
                check(32'(t >= 130 && t <= 134), 32'h1);
            end
            if (i >= 2) begin
                check(32'(t >= 127 && t <= 130), 32'h1);
            end
        end
        check({31'h0, irq}, 32'h0);
        rd(8'h00, 32'hba);
        wr(8'h00, 32'h1a);
        repeat (3) @(posedge clk);
        check({31'h0, busy}, 32'h0);
        rd(8'h00, 32'h1a);
        wait_smp(c, t);
        check(32'(t >= 400), 32'h1);
        rd(8'h0c, rexp(3'h1));
        rd(8'h08, rexp(3'h0));
    endtask

    task automatic t_trig();
        logic [2:0] c;
        int t;
        wr(8'h04, 32'h80);
        rd(8'h04, 32'hff);
        wr(8'h00, 32'h40);
        trig_n <= 1'b0;
        wait_smp(c, t);
        check(32'(t < 10), 32'h1);
        rd(8'h00, 32'h60);
        trig_n <= 1'b1;
        wait_idle(t);
        check({31'h0, irq}, 32'h1);
        dma <= 1'b1;
        @(posedge clk);
        dma <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(8'h00, 32'h40);
        wr(8'h04, 32'h0);
        trig_n <= 1'b0;
        wait_smp(c, t);
        check(32'(t >= 400), 32'h1);
        trig_n <= 1'b1;
    endtask

    task automatic t_stby();
        logic [2:0] c;
        int t;
        wr(8'h04, 32'h80);
        wr(8'h00, 32'h30);
        wait_smp(c, t);
        check({31'h0, busy}, 32'h1);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        repeat (3) @(posedge clk);
        check({31'h0, busy}, 32'h0);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h7f);
        rd(8'h08, 32'h0);
    endtask

    // ==========================================================
    // Clock, sequence and watchdog
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'hf;
        wdat = 32'h0;
        trig_n = 1'b1;
        stby = 1'b0;
        dma = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_single();
        t_scan();
        t_trig();
        t_stby();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule

`default_nettype wire
